// ---- wait_state_memory_cycle_ctrl.sv ----
// How it works
// - chip selects come only from address bits 31 to 17.
// - three spare selects decode user regions.
// - chip selects are combinational and may glitch as the address settles.
// - memory enables are synchronous and active only inside a transfer.
// - test enable floats all chip select outputs for board test.
// - a transfer starts on the asserting edge of load or store strobe.
// - start launches a 5-bit up counter stepping every clock.
// - every output except the chip selects and their drive enable is decoded from the cycle counter.
// - decoded cycle finish clears counter and machine, not strobe negation.
// - no negating strobe edges and no latch strobe are used.
// - byte strobe go waits a fixed count for bus turnaround.
// - burst and region set timing and number of read word strobes.
// - acknowledge ends every decoded write, optionally near a quad read end.
// - cycles before and between terminations are set per region.
// - undecoded accesses are ended with a bus fault.
// - writes and plain reads reuse the throttled read sequencer.
// - everything runs on one clock edge, other strobe edges ignored.
// - alternative build clears the counter while both strobes idle.
// - lane write enables combine lane selects, store, go and finish.
// - memory output enable is the primary read enable.
// - the clock is the inverted buffered bus clock.
`timescale 1ns/1ps
module wait_state_memory_cycle_ctrl (
  input  wire logic                            sys_clk_in,
  input  wire logic                            rst_in,
  input  wire logic [mem_ctrl_pkg::ADDR_W-1:0] addr_in,
  input  wire logic                            rd_n_in,
  input  wire logic                            wr_n_in,
  input  wire logic                            burst_n_in,
  input  wire logic [mem_ctrl_pkg::LANES-1:0]  byte_lane_selects_n_in,
  input  wire logic                            test_en_in,
  output logic      [mem_ctrl_pkg::NUM_CS-1:0] chip_sel_n_out,
  output logic                                 chip_sel_oe_out,
  output logic                                 read_word_strobe_n_out,
  output logic                                 ack_n_out,
  output logic                                 bus_fault_n_out,
  output logic                                 cycle_finish_n_out,
  output logic                                 byte_strobe_go_n_out,
  output logic                                 output_enable_mem_n_out,
  output logic      [mem_ctrl_pkg::LANES-1:0]  byte_lane_write_enables_n_out
);
  import mem_ctrl_pkg::*;

  cyc_state_t          state_ff;
  cyc_state_t          nxt_state;
  logic [CNT_W-1:0]    cnt_ff;
  logic [CNT_W-1:0]    nxt_cnt;
  logic                rd_n_ff;
  logic                wr_n_ff;
  logic                is_rd_ff;
  logic                burst_ff;
  logic                hit_ff;
  logic [IDX_W-1:0]    idx_ff;
  logic [NUM_CS-1:0]   dec_sel;
  logic                dec_hit;
  logic [IDX_W-1:0]    dec_idx;
  logic                start;
  logic                run;
  logic                clr_async;
  logic [CNT_W-1:0]    first_cyc;
  logic [CNT_W-1:0]    gap_cyc;
  logic [CNT_W-1:0]    last_cyc;
  logic [CNT_W-1:0]    end_cyc;
  logic                finish;
  logic                go;
  logic                word_strobe;
  logic                ack;
  logic                fault;

  // count of the last read word strobe for this region and size
  function automatic logic [CNT_W-1:0] last_word(
    input logic [CNT_W-1:0] first,
    input logic [CNT_W-1:0] gap,
    input logic             quad
  );
    logic [CNT_W-1:0] step;
    step = CNT_W'(gap + CNT_ONE);
    if (quad) begin
      last_word = CNT_W'(first + CNT_W'(3 * step));
    end else begin
      last_word = first;
    end
  endfunction

  // true when the count lands on one of the word strobe slots
  function automatic logic word_slot(
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] first,
    input logic [CNT_W-1:0] gap,
    input logic             quad
  );
    logic [CNT_W-1:0] slot;
    word_slot = 1'b0;
    slot      = first;
    for (int k = 0; k < BURST_WORDS; k++) begin
      if ((k == 0 || quad) && cnt == slot) begin
        word_slot = 1'b1;
      end
      slot = CNT_W'(slot + gap + CNT_ONE);
    end
  endfunction

  // address decoder: selects straight from the address pins
  region_decoder u_dec (
    .addr_hi_in      (addr_in),
    .test_en_in      (test_en_in),
    .sel_out         (dec_sel),
    .hit_out         (dec_hit),
    .idx_out         (dec_idx),
    .chip_sel_n_out  (chip_sel_n_out),
    .chip_sel_oe_out (chip_sel_oe_out)
  );

  // the clock is the inverted bus clock; all state uses its rising
  // edge, so half-cycle strobe edges are simply never sampled

  // previous strobe samples, used for asserting edges only
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
    end else begin
      rd_n_ff <= rd_n_in;
      wr_n_ff <= wr_n_in;
    end
  end

  // start on a falling load or store strobe while idle; negation is
  // never looked at because it lands in the setup window
  assign run   = (state_ff == ST_RUN);
  assign start = !run && ((rd_n_ff && !rd_n_in) ||
                          (wr_n_ff && !wr_n_in));

  // alternative build: both strobes idle clear the counter at once
  assign clr_async = rst_in | (ASYNC_CLEAR & rd_n_in & wr_n_in);

  // transfer attributes captured at start; glitches are over by then
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      is_rd_ff <= 1'b0;
      burst_ff <= 1'b0;
      hit_ff   <= 1'b0;
      idx_ff   <= '0;
    end else if (start) begin
      is_rd_ff <= !rd_n_in;
      burst_ff <= !rd_n_in && !burst_n_in;
      hit_ff   <= dec_hit;
      idx_ff   <= dec_idx;
    end
  end

  // per-region timing table lookup
  assign first_cyc = FIRST_CYC[idx_ff];
  assign gap_cyc   = GAP_CYC[idx_ff];
  assign last_cyc  = last_word(first_cyc, gap_cyc, burst_ff);

  // one sequencer for all kinds: a write or a single read is just a
  // throttled read that ends early
  always_comb begin
    if (!hit_ff) begin
      end_cyc = CNT_W'(FAULT_CYC + CNT_ONE);
    end else if (is_rd_ff) begin
      end_cyc = CNT_W'(last_cyc + CNT_ONE);
    end else begin
      end_cyc = CNT_W'(WR_ACK_CYC[idx_ff] + CNT_ONE);
    end
  end

  // cycle finish is decoded, not taken from the strobe negation
  assign finish = run && (cnt_ff == end_cyc);

  // machine: idle until a start, run until the decoded finish
  always_comb begin
    case (state_ff)
      ST_IDLE: begin
        nxt_state = start ? ST_RUN : ST_IDLE;
      end
      ST_RUN: begin
        nxt_state = finish ? ST_IDLE : ST_RUN;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // counter: 1 on the start edge, +1 each clock, 0 at finish or idle
  always_comb begin
    if (!run) begin
      nxt_cnt = start ? CNT_ONE : CNT_ZERO;
    end else if (finish) begin
      nxt_cnt = CNT_ZERO;
    end else begin
      nxt_cnt = CNT_W'(cnt_ff + CNT_ONE);
    end
  end

  always_ff @(posedge sys_clk_in or posedge clr_async) begin
    if (clr_async) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge sys_clk_in or posedge clr_async) begin
    if (clr_async) begin
      cnt_ff <= CNT_ZERO;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // everything below is a decode of the counter

  // byte strobes wait out the previous transfer's driver release
  assign go = run && (cnt_ff >= GO_CYC);

  // word strobes only on decoded reads, count and spacing per region
  assign word_strobe = run && hit_ff && is_rd_ff &&
                       word_slot(cnt_ff, first_cyc, gap_cyc,
                                 burst_ff);

  // write ack at its region count; quad read ack with the last word
  always_comb begin
    if (!run || !hit_ff) begin
      ack = 1'b0;
    end else if (is_rd_ff) begin
      ack = burst_ff && BURST_ACK_EN[idx_ff] &&
            (cnt_ff == last_cyc);
    end else begin
      ack = (cnt_ff == WR_ACK_CYC[idx_ff]);
    end
  end

  // undecoded access: fault, then finish next clock without waiting
  // for the processor's own load strobe release
  assign fault = run && !hit_ff && (cnt_ff == FAULT_CYC);

  // active low termination and control outputs
  assign read_word_strobe_n_out = !word_strobe;
  assign ack_n_out              = !ack;
  assign bus_fault_n_out        = !fault;
  assign cycle_finish_n_out     = !finish;
  assign byte_strobe_go_n_out   = !go;

  // read enable only inside a read, masking decoder glitches
  assign output_enable_mem_n_out =
    !(go && hit_ff && is_rd_ff && !finish);

  // per-lane write enables, dropped at finish for hold time margin
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      byte_lane_write_enables_n_out[i] =
        !(go && hit_ff && !is_rd_ff && !finish &&
          !byte_lane_selects_n_in[i]);
    end
  end

  // ---- checks ----
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence go_late_s;
    byte_strobe_go_n_out ##1 !byte_strobe_go_n_out;
  endsequence

  sequence fault_end_s;
    !bus_fault_n_out && cycle_finish_n_out ##1
    bus_fault_n_out && !cycle_finish_n_out;
  endsequence

  idle_counter_a: assert property (
    !run |-> cnt_ff == CNT_ZERO && ack_n_out && bus_fault_n_out &&
             read_word_strobe_n_out && (&byte_lane_write_enables_n_out))
    else $error("idle but counter or outputs active");

  start_count_a: assert property (
    start |=> run && cnt_ff == 5'h01 ##1 cnt_ff == 5'h02)
    else $error("counter did not launch from start");

  count_step_a: assert property (
    run && !finish |=> cnt_ff == $past(cnt_ff) + 5'h01)
    else $error("counter did not step by one");

  finish_clear_a: assert property (
    !cycle_finish_n_out |=> !run && cnt_ff == 5'h00)
    else $error("finish did not clear the machine");

  go_delay_a: assert property (
    start |=> go_late_s)
    else $error("byte strobe go not two counts late");

  unmapped_fault_a: assert property (
    start && !dec_hit |-> ##2 fault_end_s)
    else $error("undecoded access not faulted");

  write_ack_a: assert property (
    !ack_n_out && !is_rd_ff |-> ##1 !cycle_finish_n_out)
    else $error("write ack not followed by finish");

  lane_gate_a: assert property (
    !byte_lane_write_enables_n_out[0] |->
      !is_rd_ff && !byte_strobe_go_n_out && cycle_finish_n_out &&
      !byte_lane_selects_n_in[0])
    else $error("lane write enable outside write window");

  read_enable_a: assert property (
    !output_enable_mem_n_out |->
      is_rd_ff && run && byte_lane_write_enables_n_out == 4'hF)
    else $error("read enable outside read");

  word_only_read_a: assert property (
    !read_word_strobe_n_out |-> is_rd_ff && hit_ff &&
      cnt_ff >= first_cyc && cnt_ff <= last_cyc)
    else $error("word strobe outside its read slots");

  sequence last_word_s;
    !read_word_strobe_n_out && burst_ff ##1 !cycle_finish_n_out;
  endsequence

  burst_ack_a: assert property (
    !ack_n_out && is_rd_ff |-> last_word_s)
    else $error("read ack not with the last word strobe");

  one_select_a: assert property (
    $onehot0(~chip_sel_n_out) && (dec_hit == !(&chip_sel_n_out)))
    else $error("chip selects disagree with the decode");

  test_float_a: assert property (
    chip_sel_oe_out == !test_en_in)
    else $error("select drive does not follow test enable");

  fault_unmapped_a: assert property (
    !bus_fault_n_out |-> !hit_ff && cnt_ff == FAULT_CYC)
    else $error("bus fault on a decoded access or wrong count");

  go_hold_a: assert property (
    !byte_strobe_go_n_out && cycle_finish_n_out |=> !byte_strobe_go_n_out)
    else $error("byte strobe go dropped before finish");

  start_edge_a: assert property (
    $rose(run) |-> $past(start))
    else $error("transfer began without an asserting strobe edge");

endmodule

// ---- mem_ctrl_pkg.sv ----
package mem_ctrl_pkg;

  // address slice seen by the decoder and basic widths
  localparam int ADDR_HI = 31;
  localparam int ADDR_LO = 17;
  localparam int ADDR_W  = ADDR_HI - ADDR_LO + 1;
  localparam int NUM_CS  = 8;
  localparam int IDX_W   = 3;
  localparam int CNT_W   = 5;
  localparam int LANES   = 4;

  // region bases on address bits 31:17, entry 0 is the rightmost
  // 0 sram, 1 eprom, 2 uart, 3 timer, 4 irq ctl, 5..7 spare user
  localparam logic [NUM_CS-1:0][ADDR_W-1:0] REGION_BASE = {
    15'h0F50, 15'h0F40, 15'h0F30, 15'h0F20,
    15'h0F10, 15'h0F00, 15'h0FE0, 15'h0000};

  // per-region timing, in cycle counter values
  localparam logic [NUM_CS-1:0][CNT_W-1:0] FIRST_CYC = {
    5'h06, 5'h06, 5'h06, 5'h06, 5'h06, 5'h06, 5'h06, 5'h03};
  localparam logic [NUM_CS-1:0][CNT_W-1:0] GAP_CYC = {
    5'h02, 5'h02, 5'h02, 5'h02, 5'h02, 5'h02, 5'h04, 5'h00};
  localparam logic [NUM_CS-1:0][CNT_W-1:0] WR_ACK_CYC = {
    5'h05, 5'h05, 5'h05, 5'h05, 5'h05, 5'h05, 5'h04, 5'h03};
  // regions that also acknowledge near the end of a quad read
  localparam logic [NUM_CS-1:0] BURST_ACK_EN = 8'h03;

  // byte strobes start at this count (bus turnaround)
  localparam logic [CNT_W-1:0] GO_CYC    = 5'h02;
  // undecoded accesses are faulted at this count
  localparam logic [CNT_W-1:0] FAULT_CYC = 5'h02;
  localparam logic [CNT_W-1:0] CNT_ONE   = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 5'h00;
  // quad burst has four words
  localparam int BURST_WORDS = 4;

  // alternative build: idle strobes clear the counter asynchronously
  localparam logic ASYNC_CLEAR = 1'b0;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } cyc_state_t;

endpackage

// ---- region_decoder.sv ----
`timescale 1ns/1ps
module region_decoder (
  input  wire logic [mem_ctrl_pkg::ADDR_W-1:0] addr_hi_in,
  input  wire logic                            test_en_in,
  output logic      [mem_ctrl_pkg::NUM_CS-1:0] sel_out,
  output logic                                 hit_out,
  output logic      [mem_ctrl_pkg::IDX_W-1:0]  idx_out,
  output logic      [mem_ctrl_pkg::NUM_CS-1:0] chip_sel_n_out,
  output logic                                 chip_sel_oe_out
);
  import mem_ctrl_pkg::*;

  // pure combinational match on the upper address bits; no latch
  // strobe gating, so selects may glitch while the address settles
  always_comb begin
    sel_out = '0;
    hit_out = 1'b0;
    idx_out = '0;
    for (int i = 0; i < NUM_CS; i++) begin
      if (addr_hi_in == REGION_BASE[i]) begin
        sel_out[i] = 1'b1;
        hit_out    = 1'b1;
        idx_out    = IDX_W'(i);
      end
    end
  end

  // upper three selects are the spare user regions
  assign chip_sel_n_out = ~sel_out;

  // test enable floats every select for board test
  assign chip_sel_oe_out = ~test_en_in;

endmodule

// ---- cpu_bus_model.sv ----
`timescale 1ns/1ps
module cpu_bus_model (
  input  wire logic                             clk_in,
  input  wire logic                             rws_n_in,
  input  wire logic                             ack_n_in,
  input  wire logic                             fault_n_in,
  output logic      [mem_ctrl_pkg::ADDR_W-1:0] addr_out,
  output logic                                  rd_n_out,
  output logic                                  wr_n_out,
  output logic                                  burst_n_out,
  output logic      [mem_ctrl_pkg::LANES-1:0]  lanes_n_out
);
  import mem_ctrl_pkg::*;

  // bus idle at time zero, strobes negated
  initial begin
    addr_out    = '0;
    rd_n_out    = 1'b1;
    wr_n_out    = 1'b1;
    burst_n_out = 1'b1;
    lanes_n_out = 4'hf;
  end

  // one transfer: strobes move on the falling edge like the processor
  task automatic xfer(input logic [ADDR_W-1:0] a, input bit wr,
                      input bit quad, input logic [LANES-1:0] ln,
                      input int gap);
    int  words;
    int  k;
    bit  done;
    words = 0;
    done  = 0;
    @(negedge clk_in);
    addr_out    <= a;
    lanes_n_out <= ln;
    burst_n_out <= wr | !quad;
    if (wr) wr_n_out <= 1'b0;
    else rd_n_out <= 1'b0;
    // mid-cycle look equals sampling at the next rising edge
    for (k = 0; k < 40 && !done; k++) begin
      @(negedge clk_in);
      if (!rws_n_in) words++;
      done = !fault_n_in || (wr && !ack_n_in) ||
             (!wr && words == (quad ? BURST_WORDS : 1));
    end
    // negate half a cycle after the terminating edge
    @(negedge clk_in);
    rd_n_out    <= 1'b1;
    wr_n_out    <= 1'b1;
    burst_n_out <= 1'b1;
    addr_out    <= ~a; // released lines must not look stable
    lanes_n_out <= ~ln;
    repeat (gap) @(negedge clk_in);
  endtask
endmodule

// ---- wait_state_memory_cycle_ctrl_test.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module wait_state_memory_cycle_ctrl_test;
  import mem_ctrl_pkg::*;
  logic                  sys_clk_in = 1'b0; // low from the start, no edge
  logic                  rst_in;
  logic                  test_en_in;
  logic [ADDR_W-1:0]     addr_in;
  logic                  rd_n_in;
  logic                  wr_n_in;
  logic                  burst_n_in;
  logic [LANES-1:0]      byte_lane_selects_n_in;
  logic [NUM_CS-1:0]     chip_sel_n_out;
  logic                  chip_sel_oe_out;
  logic                  read_word_strobe_n_out;
  logic                  ack_n_out;
  logic                  bus_fault_n_out;
  logic                  cycle_finish_n_out;
  logic                  byte_strobe_go_n_out;
  logic                  output_enable_mem_n_out;
  logic [LANES-1:0]      byte_lane_write_enables_n_out;
  logic [9:0]            outs;
  int                    n_fail;
  int                    n_checks;
  int                    seed;

  assign outs = {read_word_strobe_n_out, ack_n_out, bus_fault_n_out,
                 cycle_finish_n_out, byte_strobe_go_n_out,
                 output_enable_mem_n_out, byte_lane_write_enables_n_out};

  wait_state_memory_cycle_ctrl dut (
    .sys_clk_in, .rst_in, .addr_in, .rd_n_in, .wr_n_in, .burst_n_in,
    .byte_lane_selects_n_in, .test_en_in, .chip_sel_n_out,
    .chip_sel_oe_out, .read_word_strobe_n_out, .ack_n_out,
    .bus_fault_n_out, .cycle_finish_n_out, .byte_strobe_go_n_out,
    .output_enable_mem_n_out, .byte_lane_write_enables_n_out);

  cpu_bus_model cpu (
    .clk_in(sys_clk_in), .rws_n_in(read_word_strobe_n_out),
    .ack_n_in(ack_n_out), .fault_n_in(bus_fault_n_out),
    .addr_out(addr_in), .rd_n_out(rd_n_in), .wr_n_out(wr_n_in),
    .burst_n_out(burst_n_in), .lanes_n_out(byte_lane_selects_n_in));

  // 250 MHz bus clock
  initial begin
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  // region index of an address, -1 when nothing decodes
  function automatic int find(input logic [ADDR_W-1:0] a);
    for (int i = 0; i < NUM_CS; i++) if (a == REGION_BASE[i]) return i;
    return -1;
  endfunction

  function automatic logic [NUM_CS-1:0] cs_exp(input logic [ADDR_W-1:0] a);
    logic [NUM_CS-1:0] v;
    for (int i = 0; i < NUM_CS; i++) v[i] = !(a == REGION_BASE[i]);
    return v;
  endfunction

  // counter value of the finish pulse
  function automatic int fin_of(input int r, input bit wr, input bit q);
    if (r < 0) return FAULT_CYC + 1;
    if (wr) return WR_ACK_CYC[r] + 1;
    return FIRST_CYC[r] + (q ? BURST_WORDS - 1 : 0) * (GAP_CYC[r] + 1) + 1;
  endfunction

  // expected outputs (active low) in counter cycle c
  function automatic logic [9:0] exp_of(input int r, input bit wr,
      input bit q, input logic [3:0] ln, input int c);
    int         f;
    int         d;
    logic [9:0] v;
    f = fin_of(r, wr, q);
    v = '0;
    v[5] = c >= GO_CYC && c <= f;
    v[6] = c == f;
    if (r < 0) v[7] = c == FAULT_CYC;
    else if (wr) begin
      v[8] = c == f - 1;
      v[3:0] = (c >= GO_CYC && c < f) ? ~ln : 4'h0;
    end else begin
      d = c - FIRST_CYC[r];
      v[9] = d >= 0 && d % (GAP_CYC[r] + 1) == 0 &&
             d / (GAP_CYC[r] + 1) < (q ? BURST_WORDS : 1);
      v[8] = q && BURST_ACK_EN[r] && c == f - 1;
      v[4] = c >= GO_CYC && c < f;
    end
    return ~v;
  endfunction

  // one transfer with cycle-by-cycle comparison up to one idle cycle
  task automatic run(input logic [ADDR_W-1:0] a, input bit wr, input bit q,
                     input logic [3:0] ln, input int gap);
    int         r;
    int         f;
    logic [9:0] want;
    r = find(a);
    f = fin_of(r, wr, q);
    fork
      cpu.xfer(a, wr, q, ln, gap);
      begin
        @(negedge sys_clk_in);
        for (int c = 1; c <= f + 1; c++) begin
          @(negedge sys_clk_in);
          #1;
          // enables are expected off as well when nothing decodes
          want = exp_of(r, wr, q, ln, c);
          `CHK(outs[9:6], want[9:6])
          `CHK(outs[5:0], want[5:0])
          if (!test_en_in) `CHK(chip_sel_n_out, cs_exp(addr_in))
          `CHK(chip_sel_oe_out, logic'(!test_en_in))
        end
      end
    join
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // main sequence: corners per region, then seeded random traffic
  initial begin
    logic [ADDR_W-1:0] a;
    int                j;
    seed = 74111;
    n_fail = 0;
    n_checks = 0;
    rst_in = 1'b1;
    test_en_in = 1'b0;
    repeat (20) @(negedge sys_clk_in);
    `CHK(chip_sel_n_out, cs_exp(addr_in))
    `CHK(outs, 10'h3ff)
    rst_in = 1'b0;
    for (int i = 0; i < NUM_CS; i++) begin
      run(REGION_BASE[i], 0, 0, 4'h0, 0);
      run(REGION_BASE[i], 0, 1, 4'h0, 1);
      run(REGION_BASE[i], 1, 0, 4'hf ^ (4'h1 << i[1:0]), 0);
    end
    run(15'h7fff, 0, 1, 4'h0, 0);
    run(15'h7fff, 1, 0, 4'h0, 0);
    test_en_in = 1'b1;
    run(REGION_BASE[0], 1, 0, 4'h0, 0);
    test_en_in = 1'b0;
    // random mix; undecoded addresses come from the two extra picks
    for (int k = 0; k < 60; k++) begin
      j = $unsigned($random(seed)) % (NUM_CS + 2);
      a = (j < NUM_CS) ? REGION_BASE[j] : 15'($random(seed));
      test_en_in = 1'($random(seed));
      run(a, 1'($random(seed)), 1'($random(seed)), 4'($random(seed)),
          $unsigned($random(seed)) % 3);
    end
    summarize;
  end

  // a stuck handshake would otherwise hang the run
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize;
  end
endmodule
